/* rtl/mau_modulo_address_update.sv */
// Address-update datapath with modulo arithmetic and the offset interlock.
`timescale 1ns/1ns
`include "mau_cfg.svh"

module mau_modulo_address_update (
    input wire logic clk,
    input wire logic rst,
    input wire logic issueValid,
    input wire mau_pkg::mau_mode_e issueMode,
    input wire mau_pkg::mau_sel_e issueSel,
    input wire mau_pkg::mau_word_t issueDisp,
    input wire mau_pkg::mau_wr_e writeKind,
    input wire mau_pkg::mau_sel_e writeSel,
    input wire mau_pkg::mau_word_t writeData,
    output logic stall,
    output logic addrValid,
    output mau_pkg::mau_word_t effAddr,
    output mau_pkg::mau_word_t firstModuloPointer,
    output mau_pkg::mau_word_t secondModuloPointer,
    output mau_pkg::mau_word_t thirdLinearPointer,
    output mau_pkg::mau_word_t fourthLinearPointer,
    output mau_pkg::mau_word_t stackPointer,
    output mau_pkg::mau_word_t offsetRegister,
    output mau_pkg::mau_word_t moduloModifierRegister
);

    // ************************************************************
    // Register state
    // ************************************************************
    mau_pkg::mau_word_t ptr_reg [0:4];
    mau_pkg::mau_word_t offset_reg;
    mau_pkg::mau_word_t modifier_reg;
    logic offMoved_reg;
    logic stalled_reg;

    // ************************************************************
    // Modulo arithmetic
    // ************************************************************
    // Mask with ones over the k low bits: size-1 rounded up to 2^k-1.
    function automatic mau_pkg::mau_word_t blockMask(input mau_pkg::mau_word_t m);
        mau_pkg::mau_word_t r;
        r = {2'h0, m[`MAU_SIZE_MSB:0]};
        r = r | (r >> 1);
        r = r | (r >> 2);
        r = r | (r >> 4);
        r = r | (r >> 8);
        return r;
    endfunction : blockMask

    mau_pkg::mau_word_t curPtr;
    mau_pkg::mau_word_t step;
    mau_pkg::mau_word_t sizeField;
    mau_pkg::mau_word_t modSize;
    mau_pkg::mau_word_t kMask;
    mau_pkg::mau_word_t base;
    mau_pkg::mau_word_t upper;
    mau_pkg::mau_word_t linSum;
    mau_pkg::mau_word_t wrapUp;
    mau_pkg::mau_word_t wrapDown;
    mau_pkg::mau_word_t modResult;
    mau_pkg::mau_word_t newPtr;
    logic modEnable;
    logic isBlockSkip;
    logic writesPtr;
    logic useOffset;
    logic needStall;
    logic fire;

    assign curPtr = ptr_reg[issueSel];
    assign modEnable = (modifier_reg != `MAU_MOD_RESET) &&
        ((issueSel == mau_pkg::MAU_SEL_P0) ||
         (issueSel == mau_pkg::MAU_SEL_P1 && modifier_reg[`MAU_BOTH_BIT]));
    assign step = (issueMode == mau_pkg::MAU_POST_INC) ? 16'h0001 :
                  (issueMode == mau_pkg::MAU_POST_DEC) ? 16'hFFFF :
                  (issueMode == mau_pkg::MAU_POST_ADD_OFF) ? offset_reg : 16'h0000;
    // The enable bit of the second pointer must not take part in size compares.
    assign sizeField = {2'h0, modifier_reg[`MAU_SIZE_MSB:0]};
    assign modSize = sizeField + 16'h0001;
    assign kMask = blockMask(modifier_reg);
    assign base = curPtr & ~kMask;
    assign upper = base + modSize - 16'h0001;
    assign linSum = curPtr + step;
    // One wrap only: a single size correction is applied either way.
    assign wrapUp = linSum - modSize;
    assign wrapDown = linSum + modSize;
    // Positive offset with the k low bits clear and above the size field.
    assign isBlockSkip = (issueMode == mau_pkg::MAU_POST_ADD_OFF) && !offset_reg[15] &&
        ((offset_reg & kMask) == 16'h0000) && (offset_reg > sizeField);
    assign modResult = isBlockSkip ? linSum :
        (step[15] ? ((linSum < base || linSum > curPtr) ? wrapDown : linSum) :
         (linSum > upper) ? wrapUp : linSum);
    assign newPtr = modEnable ? modResult : linSum;
    assign writesPtr = (issueMode == mau_pkg::MAU_POST_INC) ||
        (issueMode == mau_pkg::MAU_POST_DEC) || (issueMode == mau_pkg::MAU_POST_ADD_OFF);

    // ************************************************************
    // Interlock
    // ************************************************************
    // Only a move to the offset register arms the interlock; pointer,
    // modifier and bit-field writes are the program's responsibility.
    assign useOffset = (issueMode == mau_pkg::MAU_POST_ADD_OFF) ||
        (issueMode == mau_pkg::MAU_INDEX_OFF);
    assign needStall = issueValid && useOffset && offMoved_reg && !stalled_reg;
    assign stall = needStall;
    assign fire = issueValid && !needStall;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            offMoved_reg <= 1'b0;
            stalled_reg <= 1'b0;
        end else begin
            offMoved_reg <= (writeKind == mau_pkg::MAU_WR_MOVE_OFF);
            stalled_reg <= needStall;
        end
    end

    // ************************************************************
    // Registers and address output
    // ************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_ptr
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    ptr_reg[gi] <= `MAU_PTR_RESET;
                end else if (fire && writesPtr && issueSel == gi) begin
                    ptr_reg[gi] <= newPtr;
                end else if (writeKind == mau_pkg::MAU_WR_PTR && writeSel == gi) begin
                    ptr_reg[gi] <= writeData;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            offset_reg <= `MAU_PTR_RESET;
            modifier_reg <= `MAU_MOD_RESET;
            addrValid <= 1'b0;
            effAddr <= `MAU_PTR_RESET;
        end else begin
            if (writeKind == mau_pkg::MAU_WR_MOVE_OFF || writeKind == mau_pkg::MAU_WR_BITFIELD_OFF) begin
                offset_reg <= writeData;
            end
            if (writeKind == mau_pkg::MAU_WR_MOD) begin
                modifier_reg <= writeData;
            end
            addrValid <= fire;
            if (fire) begin
                effAddr <= (issueMode == mau_pkg::MAU_INDEX_DISP) ? curPtr + issueDisp :
                           (issueMode == mau_pkg::MAU_INDEX_OFF) ? curPtr + offset_reg : curPtr;
            end
        end
    end

    assign firstModuloPointer = ptr_reg[0];
    assign secondModuloPointer = ptr_reg[1];
    assign thirdLinearPointer = ptr_reg[2];
    assign fourthLinearPointer = ptr_reg[3];
    assign stackPointer = ptr_reg[4];
    assign offsetRegister = offset_reg;
    assign moduloModifierRegister = modifier_reg;

    // ************************************************************
    // Checks
    // ************************************************************
    offset_stall_a: assert property (@(posedge clk) disable iff (rst)
        (writeKind == mau_pkg::MAU_WR_MOVE_OFF) ##1 (issueValid && useOffset) |-> stall ##1 !stall)
        else $error("offset move did not stall exactly one cycle");
    no_other_stall_a: assert property (@(posedge clk) disable iff (rst)
        (writeKind != mau_pkg::MAU_WR_MOVE_OFF) |=> !stall)
        else $error("stall without a preceding offset move");
    plain_use_a: assert property (@(posedge clk) disable iff (rst)
        (issueValid && !useOffset) |-> !stall ##1 addrValid)
        else $error("extra cycle inserted without offset use");
    stall_then_fire_a: assert property (@(posedge clk) disable iff (rst)
        stall && issueValid |=> issueValid |-> !stall ##1 addrValid)
        else $error("stalled instruction not issued next cycle");
    wrap_up_a: assert property (@(posedge clk) disable iff (rst)
        (fire && writesPtr && modEnable && !isBlockSkip && !step[15] && linSum > upper)
        |=> ptr_reg[$past(issueSel)] == $past(wrapUp))
        else $error("pointer did not wrap at upper boundary");
    linear_ptr_a: assert property (@(posedge clk) disable iff (rst)
        (fire && writesPtr && issueSel == mau_pkg::MAU_SEL_P2) |=> thirdLinearPointer == $past(linSum))
        else $error("linear pointer updated with modulo");
    second_mod_a: assert property (@(posedge clk) disable iff (rst)
        (fire && writesPtr && issueSel == mau_pkg::MAU_SEL_P1 && !modifier_reg[`MAU_BOTH_BIT])
        |=> secondModuloPointer == $past(linSum))
        else $error("second pointer modulo without enable bit");
    wrap_down_a: assert property (@(posedge clk) disable iff (rst)
        (fire && writesPtr && modEnable && !isBlockSkip && step[15] && linSum < base)
        |=> ptr_reg[$past(issueSel)] == $past(linSum + modSize))
        else $error("pointer did not wrap at lower boundary");
    block_skip_a: assert property (@(posedge clk) disable iff (rst)
        (fire && issueMode == mau_pkg::MAU_POST_ADD_OFF && modEnable && !offset_reg[15] &&
        ((offset_reg & kMask) == 16'h0000) && offset_reg > sizeField)
        |=> ptr_reg[$past(issueSel)] == $past(curPtr + offset_reg))
        else $error("block multiple offset did not skip linearly");
    above_buf_a: assert property (@(posedge clk) disable iff (rst)
        (fire && writesPtr && modEnable && step == 16'h0000 && curPtr > upper)
        |=> ptr_reg[$past(issueSel)] == $past(curPtr - modSize))
        else $error("pointer above buffer not pulled back");
    in_buffer_a: assert property (@(posedge clk) disable iff (rst)
        (fire && modEnable && (issueMode == mau_pkg::MAU_POST_INC ||
        issueMode == mau_pkg::MAU_POST_DEC) && curPtr >= base && curPtr <= upper)
        |=> ptr_reg[$past(issueSel)] >= $past(base) && ptr_reg[$past(issueSel)] <= $past(upper))
        else $error("modulo step left the buffer");
    bitfield_stall_a: assert property (@(posedge clk) disable iff (rst)
        (writeKind == mau_pkg::MAU_WR_BITFIELD_OFF) |=> !stall)
        else $error("bit-field write to offset stalled");
    index_off_a: assert property (@(posedge clk) disable iff (rst)
        (fire && issueMode == mau_pkg::MAU_INDEX_OFF) |=> effAddr == $past(curPtr + offset_reg))
        else $error("indexed address used a stale offset");
    disp_addr_a: assert property (@(posedge clk) disable iff (rst)
        (issueValid && issueMode == mau_pkg::MAU_INDEX_DISP) |-> !stall ##1 effAddr == $past(curPtr + issueDisp))
        else $error("displacement address wrong or stalled");

endmodule : mau_modulo_address_update

/* rtl/mau_cfg.svh */
// Constants of the modulo address update datapath.
`ifndef MAU_CFG_SVH
`define MAU_CFG_SVH
`define MAU_AW 16
`define MAU_SIZE_MSB 13
`define MAU_BOTH_BIT 15
`define MAU_PTR_RESET 16'h0000
`define MAU_MOD_RESET 16'hFFFF
`define MAU_STALL_CYCLES 1
`endif

/* rtl/mau_pkg.sv */
// Types of the modulo address update datapath.
package mau_pkg;
    typedef logic [15:0] mau_word_t;
    typedef enum logic [2:0] {
        MAU_NO_UPDATE,
        MAU_POST_INC,
        MAU_POST_DEC,
        MAU_POST_ADD_OFF,
        MAU_INDEX_OFF,
        MAU_INDEX_DISP
    } mau_mode_e;
    typedef enum logic [2:0] {
        MAU_SEL_P0,
        MAU_SEL_P1,
        MAU_SEL_P2,
        MAU_SEL_P3,
        MAU_SEL_SP
    } mau_sel_e;
    typedef enum logic [2:0] {
        MAU_WR_NONE,
        MAU_WR_MOVE_OFF,
        MAU_WR_BITFIELD_OFF,
        MAU_WR_PTR,
        MAU_WR_MOD
    } mau_wr_e;
endpackage : mau_pkg

/* testbench/mau_pipe_model.sv */
// Pipeline control model that presents address instructions to the datapath.
`timescale 1ns/1ns
module mau_pipe_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic stall,
    input wire logic instValid,
    output logic issueValid,
    output int stallCount
);
    // Decode keeps the instruction presented while stalled, so no request is lost.
    assign issueValid = instValid;
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            stallCount <= 0;
        else if (instValid && stall)
            stallCount <= stallCount + 1;
    end
endmodule : mau_pipe_model

/* testbench/mau_modulo_address_update_tb.sv */
// Self-checking bench of the modulo address update datapath.
`timescale 1ns/1ns
module mau_modulo_address_update_tb;
    localparam mau_pkg::mau_wr_e wMov = mau_pkg::MAU_WR_MOVE_OFF;
    localparam mau_pkg::mau_wr_e wPtr = mau_pkg::MAU_WR_PTR;
    localparam mau_pkg::mau_wr_e wMod = mau_pkg::MAU_WR_MOD;
    localparam mau_pkg::mau_mode_e mInc = mau_pkg::MAU_POST_INC;
    localparam mau_pkg::mau_mode_e mAdd = mau_pkg::MAU_POST_ADD_OFF;
    localparam mau_pkg::mau_sel_e s0 = mau_pkg::MAU_SEL_P0;
    localparam mau_pkg::mau_sel_e s1 = mau_pkg::MAU_SEL_P1;
    localparam mau_pkg::mau_sel_e s3 = mau_pkg::MAU_SEL_P3;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic instValid = 1'b0;
    logic stall, addrValid, issueValid;
    mau_pkg::mau_mode_e issueMode = mau_pkg::MAU_NO_UPDATE;
    mau_pkg::mau_sel_e issueSel = s0;
    mau_pkg::mau_sel_e writeSel = s0;
    mau_pkg::mau_wr_e writeKind = mau_pkg::MAU_WR_NONE;
    mau_pkg::mau_word_t issueDisp = 16'h0000;
    mau_pkg::mau_word_t writeData = 16'h0000;
    mau_pkg::mau_word_t effAddr, p0, p1, p2, p3, sp, off, mdf;
    int stallCount;
    int errors = 0;
    int comparisons = 0;
    initial begin
        forever #2 clk = ~clk;
    end
    mau_pipe_model pipe (.clk(clk), .rst(rst), .stall(stall), .instValid(instValid),
        .issueValid(issueValid), .stallCount(stallCount));
    mau_modulo_address_update uut (.clk(clk), .rst(rst), .issueValid(issueValid),
        .issueMode(issueMode), .issueSel(issueSel), .issueDisp(issueDisp),
        .writeKind(writeKind), .writeSel(writeSel), .writeData(writeData), .stall(stall),
        .addrValid(addrValid), .effAddr(effAddr), .firstModuloPointer(p0),
        .secondModuloPointer(p1), .thirdLinearPointer(p2), .fourthLinearPointer(p3),
        .stackPointer(sp), .offsetRegister(off), .moduloModifierRegister(mdf));
    task automatic check(input mau_pkg::mau_word_t seen, input mau_pkg::mau_word_t exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic finish_test();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : finish_test
    task automatic wr(input mau_pkg::mau_wr_e k, input mau_pkg::mau_sel_e s,
            input mau_pkg::mau_word_t d);
        writeKind <= k;
        writeSel <= s;
        writeData <= d;
        @(posedge clk);
    endtask : wr
    // Presents one instruction, counts stall cycles and checks the address and pointer.
    task automatic issue(input mau_pkg::mau_mode_e m, input mau_pkg::mau_sel_e s,
            input logic stl, input logic cp, input mau_pkg::mau_word_t ea,
            input mau_pkg::mau_word_t ep, input mau_pkg::mau_word_t d = 16'h0000);
        int n0;
        logic st;
        n0 = stallCount;
        writeKind <= mau_pkg::MAU_WR_NONE;
        issueMode <= m;
        issueSel <= s;
        issueDisp <= d;
        instValid <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            #1;
            st = stall;
            @(posedge clk);
            if (st !== 1'b1)
                break;
        end
        instValid <= 1'b0;
        #1;
        if (st !== 1'b0) begin
            errors++;
            finish_test();
        end
        check(16'(stallCount - n0), 16'(stl));
        check(16'(addrValid), 16'h0001);
        if (cp) begin
            check(effAddr, ea);
            check(s == s0 ? p0 : s == s1 ? p1 : s == s3 ? p3 : s == 3'h2 ? p2 : sp, ep);
        end
        @(posedge clk);
    endtask : issue
    task automatic t_reset();
        check(p0 | p1 | p2 | p3 | sp | off, 16'h0000);
        check(mdf, 16'hFFFF);
        $display("test reset done");
    endtask : t_reset
    task automatic t_wrap();
        wr(wMod, s0, 16'h0004);
        wr(wPtr, s0, 16'h0800);
        wr(wMov, s0, 16'h0003);
        issue(mAdd, s0, 1'b1, 1'b1, 16'h0800, 16'h0803);
        issue(mAdd, s0, 1'b0, 1'b1, 16'h0803, 16'h0801);
        issue(mau_pkg::MAU_POST_DEC, s0, 1'b0, 1'b1, 16'h0801, 16'h0800);
        issue(mau_pkg::MAU_POST_DEC, s0, 1'b0, 1'b1, 16'h0800, 16'h0804);
        wr(wPtr, mau_pkg::MAU_SEL_P2, 16'h0804);
        issue(mau_pkg::MAU_INDEX_DISP, mau_pkg::MAU_SEL_P2, 1'b0, 1'b1, 16'h0814,
            16'h0804, 16'h0010);
        issue(mInc, mau_pkg::MAU_SEL_P2, 1'b0, 1'b1, 16'h0804, 16'h0805);
        wr(wPtr, s1, 16'h0804);
        issue(mInc, s1, 1'b0, 1'b1, 16'h0804, 16'h0805);
        wr(wPtr, s1, 16'h0804);
        wr(wMod, s0, 16'h8004);
        @(posedge clk);
        issue(mInc, s1, 1'b0, 1'b1, 16'h0804, 16'h0800);
        $display("test wrap done");
    endtask : t_wrap
    task automatic t_skip();
        wr(wMod, s0, 16'h0004);
        wr(wPtr, s0, 16'h0801);
        wr(wMov, s0, 16'h0010);
        issue(mAdd, s0, 1'b1, 1'b1, 16'h0801, 16'h0811);
        wr(wMod, s0, 16'h0005);
        wr(wPtr, s0, 16'h0006);
        issue(mau_pkg::MAU_NO_UPDATE, s0, 1'b0, 1'b1, 16'h0006, 16'h0006);
        wr(wMov, s0, 16'h0000);
        issue(mAdd, s0, 1'b1, 1'b1, 16'h0006, 16'h0000);
        $display("test skip done");
    endtask : t_skip
    task automatic t_interlock();
        wr(wMov, s0, 16'h0001);
        issue(mau_pkg::MAU_INDEX_OFF, mau_pkg::MAU_SEL_SP, 1'b1, 1'b1, 16'h0001,
            16'h0000);
        wr(wMov, s0, 16'h0002);
        issue(mInc, s3, 1'b0, 1'b1, 16'h0000, 16'h0001);
        wr(mau_pkg::MAU_WR_BITFIELD_OFF, s0, 16'h0005);
        issue(mAdd, s3, 1'b0, 1'b0, 16'h0000, 16'h0000);
        check(off, 16'h0005);
        wr(wPtr, s3, 16'h0020);
        issue(mInc, s3, 1'b0, 1'b0, 16'h0000, 16'h0000);
        wr(wMod, s0, 16'h0007);
        issue(mInc, s0, 1'b0, 1'b0, 16'h0000, 16'h0000);
        check(mdf, 16'h0007);
        $display("test interlock done");
    endtask : t_interlock
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_wrap();
        t_skip();
        t_interlock();
        finish_test();
    end
endmodule : mau_modulo_address_update_tb
